// ===== hdl/spia_map.svh
// Register offsets, field positions, reset values for the interrupt aggregation block
`ifndef SPIA_MAP_SVH
`define SPIA_MAP_SVH

// Byte offsets on the Wishbone slave
`define SPIA_UP_CTRL     8'h00
`define SPIA_UP_PMNXT    8'h04
`define SPIA_UP_STAT     8'h08
`define SPIA_DS_BASE     8'h10
`define SPIA_DS_STRIDE   8'h10
`define SPIA_DS_CTRL     8'h00
`define SPIA_DS_STAT     8'h04

// Control field positions (upstream and downstream share the low three)
`define SPIA_B_MSI_EN    0
`define SPIA_B_LEG_DIS   1
`define SPIA_B_SRC_EN    2
`define SPIA_B_SRC2_EN   3
`define SPIA_B_UNLOCK    3

// Status field positions
`define SPIA_B_STAT_AUX  4

// Reset values and the MSI capability pointer
`define SPIA_CTRL_RST    4'h0
`define SPIA_PMNXT_RST   8'h00
`define SPIA_MSI_CAP_PTR 8'hd0

`endif

// ===== hdl/spia_pkg.sv
// Types shared by the interrupt aggregation block
`default_nettype none
package spia_pkg;
   typedef enum logic {
      SPIA_MSG_IDLE,
      SPIA_MSG_SEND
   } spia_msg_st_t;

   typedef logic [3:0] spia_intx_t;
endpackage
`default_nettype wire

// ===== hdl/spia_irq_agg.sv
// Switch port interrupt generation, INTx aggregation and upstream message emission
`include "spia_map.svh"
`default_nettype none
module spia_irq_agg #(
   parameter int NUM_DS = 3,
   parameter int ADDR_W = 8
) (
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   input  wire logic                     wb_cyc_i,
   input  wire logic                     wb_stb_i,
   input  wire logic                     wb_we_i,
   input  wire logic [ADDR_W-1:0]        wb_adr_i,
   input  wire logic [3:0]               wb_sel_i,
   input  wire logic [31:0]              wb_dat_i,
   output logic      [31:0]              wb_dat_o,
   output logic                          wb_ack_o,
   input  wire logic                     up_err_i,
   input  wire logic [NUM_DS-1:0]        hp_irq_i,
   input  wire logic [NUM_DS-1:0]        link_bw_mgmt_status_i,
   input  wire logic [NUM_DS-1:0]        link_autonomous_bw_status_i,
   input  wire logic [NUM_DS-1:0][3:0]   rx_intx_i,
   input  wire logic [NUM_DS-1:0]        dl_up_i,
   output logic      [NUM_DS:0]          up_msi_req_o,
   output logic      [NUM_DS-1:0]        ds_assert_inta_o,
   output logic      [NUM_DS-1:0]        ds_deassert_inta_o,
   output logic                          up_msg_valid_o,
   output logic                          up_msg_assert_o,
   output logic      [1:0]               up_msg_line_o,
   input  wire logic                     up_msg_ready_i,
   output logic      [7:0]               next_capability_pointer_o,
   output logic                          msi_cap_linked_o,
   output spia_pkg::spia_intx_t          upstream_irq_status_o
);

   // The mapping table is fixed for three downstream ports
   if (NUM_DS != 3) begin : g_bad_ds
      $error("spia_irq_agg serves exactly three downstream ports");
   end
   if (ADDR_W < 8) begin : g_bad_aw
      $error("spia_irq_agg needs at least 8 address bits");
   end

   // Byte address of a downstream port register
   function automatic logic [ADDR_W-1:0] ds_addr(input int k, input logic [7:0] off);
      return ADDR_W'(`SPIA_DS_BASE + k * `SPIA_DS_STRIDE + off);
   endfunction

   // Downstream line that feeds upstream line u from port index k (0 is port 2)
   function automatic logic [1:0] up_src_line(input int u, input int k);
      return 2'((u + 6 - k) % 4);
   endfunction

   logic                     ack;
   logic                     next_ack;
   logic [31:0]              rdata;
   logic [31:0]              next_rdata;
   logic [31:0]              rd_word;
   logic [3:0]               up_ctrl;
   logic [3:0]               next_up_ctrl;
   logic [7:0]               pm_next;
   logic [7:0]               next_pm_next;
   logic [NUM_DS-1:0][3:0]   ds_ctrl;
   logic [NUM_DS-1:0][3:0]   next_ds_ctrl;
   logic                     bus_wr;
   logic [NUM_DS:0][3:0]     ctl;
   logic [NUM_DS:0]          cond;
   logic [NUM_DS:0]          cond_prev;
   logic [NUM_DS:0]          rise;
   logic [NUM_DS:0]          fall;
   logic [NUM_DS:0]          msi_req;
   logic [NUM_DS:0]          next_msi_req;
   logic [NUM_DS:0]          asrt;
   logic [NUM_DS:0]          next_asrt;
   logic [NUM_DS:0]          dsrt;
   logic [NUM_DS:0]          next_dsrt;
   logic [NUM_DS:0]          own_inta;
   logic [NUM_DS:0]          next_own_inta;
   logic [NUM_DS-1:0][3:0]   ds_agg;
   logic [3:0]               up_agg;
   logic [3:0]               up_sent;
   logic [3:0]               next_up_sent;
   spia_pkg::spia_msg_st_t   msg_st;
   spia_pkg::spia_msg_st_t   next_msg_st;
   logic                     msg_assert;
   logic                     next_msg_assert;
   logic [1:0]               msg_line;
   logic [1:0]               next_msg_line;

   // Writes land at the edge that closes the acked cycle
   assign bus_wr = wb_cyc_i & wb_stb_i & wb_we_i & ack & wb_sel_i[0];

   // Read multiplexer; unmapped words read as zero
   always_comb begin
      rd_word = 32'h0;
      if (wb_adr_i == ADDR_W'(`SPIA_UP_CTRL)) begin
         rd_word = {28'h0, up_ctrl};
      end
      if (wb_adr_i == ADDR_W'(`SPIA_UP_PMNXT)) begin
         rd_word = {24'h0, pm_next};
      end
      if (wb_adr_i == ADDR_W'(`SPIA_UP_STAT)) begin
         rd_word = {27'h0, msi_cap_linked_o, up_agg};
      end
      for (int k = 0; k < NUM_DS; k++) begin
         if (wb_adr_i == ds_addr(k, `SPIA_DS_CTRL)) begin
            rd_word = {28'h0, ds_ctrl[k]};
         end
         if (wb_adr_i == ds_addr(k, `SPIA_DS_STAT)) begin
            rd_word = {27'h0, cond[k+1], ds_agg[k]};
         end
      end
   end

   // Register file and bus answer, next values
   always_comb begin
      next_ack     = wb_cyc_i & wb_stb_i & ~ack;
      next_rdata   = rdata;
      next_up_ctrl = up_ctrl;
      next_pm_next = pm_next;
      next_ds_ctrl = ds_ctrl;
      if (next_ack & ~wb_we_i) begin
         next_rdata = rd_word;
      end
      if (bus_wr) begin
         if (wb_adr_i == ADDR_W'(`SPIA_UP_CTRL)) begin
            next_up_ctrl = wb_dat_i[3:0];
         end
         // Pointer only moves while registers are unlocked
         if (wb_adr_i == ADDR_W'(`SPIA_UP_PMNXT) && up_ctrl[`SPIA_B_UNLOCK]) begin
            next_pm_next = wb_dat_i[7:0];
         end
         for (int k = 0; k < NUM_DS; k++) begin
            if (wb_adr_i == ds_addr(k, `SPIA_DS_CTRL)) begin
               next_ds_ctrl[k] = wb_dat_i[3:0];
            end
         end
      end
   end

   // Register file and bus answer, state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack     <= 1'b0;
         rdata   <= 32'h0;
         up_ctrl <= `SPIA_CTRL_RST;
         pm_next <= `SPIA_PMNXT_RST;
         ds_ctrl <= '0;
      end else begin
         ack     <= next_ack;
         rdata   <= next_rdata;
         up_ctrl <= next_up_ctrl;
         pm_next <= next_pm_next;
         ds_ctrl <= next_ds_ctrl;
      end
   end

   assign wb_ack_o = ack;
   assign wb_dat_o = rdata;
   assign next_capability_pointer_o = pm_next;
   assign msi_cap_linked_o = (pm_next == `SPIA_MSI_CAP_PTR);

   // Per port condition; index 0 is the upstream port, inputs are live status levels
   always_comb begin
      ctl[0]  = up_ctrl;
      cond[0] = up_err_i & up_ctrl[`SPIA_B_SRC_EN];
      for (int k = 0; k < NUM_DS; k++) begin
         ctl[k+1]  = ds_ctrl[k];
         // Masking an enable or clearing a status bit drops the condition at once
         cond[k+1] = hp_irq_i[k]
                   | (link_bw_mgmt_status_i[k] & ds_ctrl[k][`SPIA_B_SRC_EN])
                   | (link_autonomous_bw_status_i[k] & ds_ctrl[k][`SPIA_B_SRC2_EN]);
      end
   end

   assign rise = cond & ~cond_prev;
   assign fall = ~cond & cond_prev;

   // MSI or INTA request per port edge
   always_comb begin
      next_own_inta = own_inta;
      for (int p = 0; p <= NUM_DS; p++) begin
         next_msi_req[p] = rise[p] & ctl[p][`SPIA_B_MSI_EN];
         next_asrt[p] = rise[p] & ~ctl[p][`SPIA_B_MSI_EN] & ~ctl[p][`SPIA_B_LEG_DIS];
         next_dsrt[p] = fall[p] & ~ctl[p][`SPIA_B_MSI_EN] & ~ctl[p][`SPIA_B_LEG_DIS];
         if (next_asrt[p]) begin
            next_own_inta[p] = 1'b1;
         end else if (next_dsrt[p]) begin
            next_own_inta[p] = 1'b0;
         end
      end
      // A dead link takes its own wire down too, so no stale line survives it
      for (int k = 0; k < NUM_DS; k++) begin
         if (!dl_up_i[k]) begin
            next_own_inta[k+1] = 1'b0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cond_prev <= '0;
         msi_req   <= '0;
         asrt      <= '0;
         dsrt      <= '0;
         own_inta  <= '0;
      end else begin
         cond_prev <= cond;
         msi_req   <= next_msi_req;
         asrt      <= next_asrt;
         dsrt      <= next_dsrt;
         own_inta  <= next_own_inta;
      end
   end

   // Every MSI, downstream ones included, leaves through the upstream port
   assign up_msi_req_o       = msi_req;
   assign ds_assert_inta_o   = asrt[NUM_DS:1];
   assign ds_deassert_inta_o = dsrt[NUM_DS:1];

   // Aggregates: downstream unmapped, upstream rotated by port number
   always_comb begin
      up_agg = {3'h0, own_inta[0]};
      for (int k = 0; k < NUM_DS; k++) begin
         ds_agg[k] = (rx_intx_i[k] | {3'h0, own_inta[k+1]}) & {4{dl_up_i[k]}};
      end
      for (int u = 0; u < 4; u++) begin
         for (int k = 0; k < NUM_DS; k++) begin
            up_agg[u] = up_agg[u] | ds_agg[k][up_src_line(u, k)];
         end
      end
   end

   assign upstream_irq_status_o = up_agg;

   // Upstream message queue: compares the live aggregate with what the root was last told.
   // Short pulses while a message waits collapse, trading fidelity for no buffer.
   always_comb begin
      logic       found;
      logic [1:0] pick;
      found           = 1'b0;
      pick            = 2'h0;
      next_msg_st     = msg_st;
      next_msg_line   = msg_line;
      next_msg_assert = msg_assert;
      next_up_sent    = up_sent;
      for (int u = 3; u >= 0; u--) begin
         if (up_agg[u] != up_sent[u]) begin
            found = 1'b1;
            pick  = 2'(u);
         end
      end
      case (msg_st)
         spia_pkg::SPIA_MSG_IDLE,
         spia_pkg::SPIA_MSG_SEND: begin
            if (msg_st == spia_pkg::SPIA_MSG_IDLE || up_msg_ready_i) begin
               next_msg_st = spia_pkg::SPIA_MSG_IDLE;
               if (found) begin
                  next_msg_st     = spia_pkg::SPIA_MSG_SEND;
                  next_msg_line   = pick;
                  next_msg_assert = up_agg[pick];
                  next_up_sent[pick] = up_agg[pick];
               end
            end
         end
         default: begin
            next_msg_st = spia_pkg::SPIA_MSG_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         msg_st     <= spia_pkg::SPIA_MSG_IDLE;
         msg_line   <= 2'h0;
         msg_assert <= 1'b0;
         up_sent    <= 4'h0;
      end else begin
         msg_st     <= next_msg_st;
         msg_line   <= next_msg_line;
         msg_assert <= next_msg_assert;
         up_sent    <= next_up_sent;
      end
   end

   assign up_msg_valid_o  = (msg_st == spia_pkg::SPIA_MSG_SEND);
   assign up_msg_line_o   = msg_line;
   assign up_msg_assert_o = msg_assert;

   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_msi_needs_en: assert property (up_msi_req_o[1] |-> $past(ctl[1][`SPIA_B_MSI_EN])
      && $past(cond[1]) && !$past(cond_prev[1]))
      else $error("MSI without enable or rising condition");
   a_inta_sets_wire: assert property (ds_assert_inta_o[0] |-> (own_inta[1] || !$past(dl_up_i[0]))
      && !$past(ctl[1][`SPIA_B_LEG_DIS]))
      else $error("Assert_INTA request mismatched");
   a_deassert_cause: assert property (ds_deassert_inta_o[2] |-> $past(cond_prev[3])
      && !$past(cond[3]) && !$past(ctl[3][`SPIA_B_MSI_EN]))
      else $error("Deassert_INTA without falling condition");
   a_cond_removed: assert property (!hp_irq_i[0] && !ds_ctrl[0][`SPIA_B_SRC_EN]
      && !ds_ctrl[0][`SPIA_B_SRC2_EN] |-> !cond[1])
      else $error("Condition stays with all causes masked");
   a_dl_down_clear: assert property (!dl_up_i[1] |-> ds_agg[1] == 4'h0 ##1 !own_inta[2])
      else $error("Link down port still drives a wire");
   a_map_line_a: assert property (up_agg[0] == (own_inta[0] | ds_agg[0][2]
      | ds_agg[1][1] | ds_agg[2][0]))
      else $error("Upstream line A mapping wrong");
   a_map_line_d: assert property (up_agg[3] == (ds_agg[0][1] | ds_agg[1][0]
      | ds_agg[2][3]))
      else $error("Upstream line D mapping wrong");
   a_msg_pending: assert property (msg_st == spia_pkg::SPIA_MSG_IDLE && up_agg != up_sent
      |=> up_msg_valid_o && up_msg_assert_o == up_sent[up_msg_line_o])
      else $error("Aggregate change not turned into a message");
   a_msg_hold: assert property (up_msg_valid_o && !up_msg_ready_i |=> up_msg_valid_o
      && $stable(up_msg_line_o) && $stable(up_msg_assert_o))
      else $error("Upstream message changed before taken");
   a_cap_locked: assert property (!up_ctrl[`SPIA_B_UNLOCK] |=> $stable(pm_next))
      else $error("Next pointer moved while locked");
   a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("Ack held two cycles");

   c_msi_sent: cover property (up_msi_req_o[2]);
   c_assert_msg: cover property (up_msg_valid_o && up_msg_ready_i && up_msg_assert_o);
   c_link_down_deassert: cover property (!dl_up_i[0] ##[1:4] up_msg_valid_o && !up_msg_assert_o);
   c_cap_linked: cover property ($rose(msi_cap_linked_o));

endmodule
`default_nettype wire

// ===== tb/spia_root_model.sv
// Root complex model: takes upstream INTx messages and tracks the line state
`default_nettype none
module spia_root_model (
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   input  wire logic       slow_i,
   input  wire logic       valid_i,
   input  wire logic       assert_i,
   input  wire logic [1:0] line_i,
   output logic            ready_o,
   output logic      [3:0] state_o,
   output int              bad_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // Accepts where valid meets ready; slow mode stalls at random to test holding
   always @(posedge clk_i) begin
      if (rst_i) begin
         ready_o <= 1'b0;
         state_o <= 4'h0;
         bad_o   <= 0;
      end else begin
         ready_o <= slow_i ? 1'($urandom_range(1)) : 1'b1;
         if (valid_i && ready_o) begin
            // A repeated message on a line means an edge was sent twice
            if (state_o[line_i] == assert_i) begin
               bad_o <= bad_o + 1;
            end
            state_o[line_i] <= assert_i;
         end
      end
   end
endmodule
`default_nettype wire

// ===== tb/switch_port_interrupt_aggregation_tb.sv
// Self-checking bench for the switch port interrupt aggregation block
`default_nettype none
module switch_port_interrupt_aggregation_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic             clk_i = 1'b0;
   logic             rst_i = 1'b1;
   logic             cyc = 1'b0, stb = 1'b0, we = 1'b0, err = 1'b0, slow = 1'b0;
   logic [3:0]       sel = 4'hf;
   logic [7:0]       adr = 8'h00;
   logic [31:0]      dat = 32'h0, wb_dat_o;
   logic [2:0]       hp = 3'h0, bwm = 3'h0, bwa = 3'h0, dl = 3'h7;
   logic [2:0][3:0]  rx = '0;
   logic [3:0]       msi_o, stat_o, root_st;
   logic [2:0]       as_o, de_o;
   logic             wb_ack_o, mv, ma, rdy, linked;
   logic [1:0]       ml;
   logic [7:0]       ptr;
   int               errors = 0, samples_checked = 0, cyc_n = 0, bad;
   int               msi_n[4] = '{0, 0, 0, 0}, as_n[3] = '{0, 0, 0}, de_n[3] = '{0, 0, 0};
   spia_irq_agg dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .up_err_i(err), .hp_irq_i(hp), .link_bw_mgmt_status_i(bwm),
      .link_autonomous_bw_status_i(bwa), .rx_intx_i(rx), .dl_up_i(dl),
      .up_msi_req_o(msi_o), .ds_assert_inta_o(as_o), .ds_deassert_inta_o(de_o),
      .up_msg_valid_o(mv), .up_msg_assert_o(ma), .up_msg_line_o(ml), .up_msg_ready_i(rdy),
      .next_capability_pointer_o(ptr), .msi_cap_linked_o(linked),
      .upstream_irq_status_o(stat_o));
   spia_root_model root (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .valid_i(mv),
      .assert_i(ma), .line_i(ml), .ready_o(rdy), .state_o(root_st), .bad_o(bad));
   always #50 clk_i = ~clk_i;
   // Pulse counters let checks ask how many requests came, not when they were sampled
   always @(posedge clk_i) begin
      cyc_n <= cyc_n + 1;
      for (int k = 0; k < 4; k++) msi_n[k] <= msi_n[k] + int'(msi_o[k] === 1'b1);
      for (int k = 0; k < 3; k++) as_n[k] <= as_n[k] + int'(as_o[k] === 1'b1);
      for (int k = 0; k < 3; k++) de_n[k] <= de_n[k] + int'(de_o[k] === 1'b1);
      if (cyc_n == 40000) begin
         errors++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("checks %0d errors %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Classic cycle: hold everything until ack is seen high at a rising edge
   // Read data is taken at that same edge, and only then is the request released
   task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= d;
      do @(posedge clk_i); while (wb_ack_o !== 1'b1);
      r = wb_dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      wb(1'b1, a, d, r);
   endtask
   task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
      logic [31:0] r;
      wb(1'b0, a, 32'h0, r);
      check(r, e);
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
      @(negedge clk_i);
   endtask
   // Upstream line l gathers line (l+2-k)%4 of port index k, plus own line A
   function automatic logic [3:0] exp_up(logic [2:0][3:0] x, logic [2:0] u, logic [2:0] own,
                                         logic e);
      logic [3:0] r;
      r = {3'h0, e};
      for (int l = 0; l < 4; l++)
         for (int k = 0; k < 3; k++)
            r[l] |= u[k] & (x[k][(l + 2 - k) % 4] | (own[k] & ((l + 2 - k) % 4 == 0)));
      return r;
   endfunction
   initial begin
      int m0, a0, d0, k, q;
      void'($urandom(32'h8291));
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      rdchk(8'h04, 32'h0);
      rdchk(8'h0c, 32'h0);
      wr(8'h04, 32'hd0);
      rdchk(8'h04, 32'h0);
      wr(8'h00, 32'h8);
      wr(8'h04, 32'hd0);
      rdchk(8'h04, 32'hd0);
      check(linked, 1'b1);
      check(ptr, 8'hd0);
      // A write without byte lane 0 must leave the pointer alone
      sel <= 4'he;
      wr(8'h04, 32'h11);
      sel <= 4'hf;
      rdchk(8'h04, 32'hd0);
      $display("test capability done");
      for (int i = 0; i < 12; i++) begin
         k = i / 4;
         wr(8'(16 * k + 16), 32'(i % 4));
         m0 = msi_n[k + 1];
         a0 = as_n[k];
         d0 = de_n[k];
         @(posedge clk_i);
         hp[k] <= 1'b1;
         tick(4);
         check(32'(msi_n[k + 1] - m0), 32'(i % 4 == 1 || i % 4 == 3));
         check(32'(as_n[k] - a0), 32'(i % 4 == 0));
         check(stat_o, exp_up('0, 3'h7, 3'(i % 4 == 0) << k, 1'b0));
         rdchk(8'(16 * k + 20), {27'h0, 1'b1, 3'h0, 1'(i % 4 == 0)});
         hp[k] <= 1'b0;
         tick(4);
         check(32'(de_n[k] - d0), 32'(i % 4 == 0));
         check(32'(msi_n[k + 1] - m0), 32'(i % 4 == 1 || i % 4 == 3));
      end
      $display("test port table done");
      k = $urandom_range(2);
      a0 = as_n[k];
      d0 = de_n[k];
      wr(8'(16 * k + 16), 32'h0);
      bwm[k] <= 1'b1;
      bwa[k] <= 1'b1;
      tick(4);
      check(32'(as_n[k] - a0), 32'h0);
      wr(8'(16 * k + 16), 32'h4);
      tick(3);
      check(32'(as_n[k] - a0), 32'h1);
      @(posedge clk_i);
      bwm[k] <= 1'b0;
      tick(3);
      check(32'(de_n[k] - d0), 32'h1);
      wr(8'(16 * k + 16), 32'h8);
      tick(3);
      check(32'(as_n[k] - a0), 32'h2);
      wr(8'(16 * k + 16), 32'h0);
      tick(3);
      check(32'(de_n[k] - d0), 32'h2);
      @(posedge clk_i);
      bwa[k] <= 1'b0;
      $display("test bandwidth done");
      wr(8'h00, 32'h4);
      err <= 1'b1;
      tick(3);
      check(stat_o, 4'h1);
      @(posedge clk_i);
      err <= 1'b0;
      tick(3);
      wr(8'h00, 32'h5);
      m0 = msi_n[0];
      err <= 1'b1;
      tick(3);
      check(32'(msi_n[0] - m0), 32'h1);
      @(posedge clk_i);
      err <= 1'b0;
      wr(8'h00, 32'h0);
      $display("test upstream error done");
      for (int i = 0; i < 24; i++) begin
         @(posedge clk_i);
         rx <= (i < 2) ? 12'hfff : 12'($urandom);
         dl <= (i == 1) ? 3'h0 : (i == 0) ? 3'h7 : 3'($urandom);
         slow <= 1'($urandom);
         tick(2);
         check(stat_o, exp_up(rx, dl, 3'h0, 1'b0));
         k = $urandom_range(2);
         rdchk(8'(16 * k + 20), {28'h0, rx[k] & {4{dl[k]}}});
         rdchk(8'h08, {27'h0, 1'b1, exp_up(rx, dl, 3'h0, 1'b0)});
         q = 0;
         while (q < 3) begin
            @(negedge clk_i);
            q = (mv === 1'b0) ? q + 1 : 0;
         end
         check(root_st, exp_up(rx, dl, 3'h0, 1'b0));
      end
      check(32'(bad), 32'h0);
      $display("test aggregation done");
      stop_test();
   end
endmodule
`default_nettype wire
